// ---- inc/olw_pkg.sv ----
// Constants and field layouts for the option latches and watchdog
package olw_pkg;
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Register addresses
  localparam logic [15:0] ADDR_OPT2 = 16'h001e;
  localparam logic [15:0] ADDR_OPT1 = 16'h001f;
  localparam logic [15:0] ADDR_WDOG = 16'hffff;
  // Reset value of both option registers
  localparam logic [7:0] OPT_RST = 8'h00;
  // Writable bits of option register two, reserved read zero
  localparam logic [7:0] OPT2_WMASK = 8'heb;
  // Answer to unmapped reads
  localparam logic [7:0] RD_NONE = 8'h00;
  // Watchdog structure
  localparam int WD_CNT_W = 6;
  localparam int PRESC_W = 12;
  // Prescaler stages below this index survive a service write
  localparam int PRESC_KEEP = 4;
  // Crystal clock cycle counts
  localparam logic [12:0] REC_SHORT = 13'h0020;
  localparam logic [12:0] REC_LONG = 13'h1000;
  localparam logic [12:0] POR_CLR_CYC = 13'h1000;
  localparam logic [5:0] RST_PULSE_CYC = 6'h20;
  // Clock-out divider select codes
  localparam logic [1:0] CKO_OFF = 2'h0;
  localparam logic [1:0] CKO_DIV1 = 2'h1;
  localparam logic [1:0] CKO_DIV2 = 2'h2;
  localparam logic [1:0] CKO_DIV4 = 2'h3;

  // Option register two, bit 7 first
  typedef struct packed {
    logic clock_output_source_sel;
    logic clock_output_div_hi;
    logic clock_output_div_lo;
    logic rsvd4;
    logic timebase_prescale_sel;
    logic rsvd2;
    logic osc_run_in_stop;
    logic serial_baud_source;
  } olw_opt2_type;

  // Option register one, bit 7 first
  typedef struct packed {
    logic watchdog_rate_sel;
    logic voltage_monitor_in_stop;
    logic voltage_monitor_reset_disable;
    logic voltage_monitor_power_disable;
    logic voltage_monitor_range_sel;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } olw_opt1_type;
endpackage : olw_pkg

// ---- rtl/olw_top.sv ----
// Write-once option registers, clock-out divider and watchdog
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module olw_top #(
  parameter int unsigned P_PRESC_W = olw_pkg::PRESC_W
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_por_n,
  input wire logic [olw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [olw_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [olw_pkg::DATA_W-1:0] i_reset_vec_lo,
  input wire logic i_bus_tick,
  input wire logic i_port_dir,
  input wire logic i_stop_exec,
  input wire logic i_stop_exit,
  input wire logic i_exit_by_reset,
  input wire logic i_monitor_mode,
  input wire logic i_break_state,
  input wire logic i_rst_vtst,
  input wire logic i_irq_vtst,
  input wire logic i_cause_clr,
  output logic [olw_pkg::DATA_W-1:0] o_rdata,
  output logic o_clkout,
  output logic o_clkout_pin_sel,
  output logic o_clkout_pin_oe,
  output logic o_tb_div128_en,
  output logic o_osc_run_in_stop,
  output logic o_serial_baud_bus,
  output logic o_lvm_power_en,
  output logic o_lvm_reset_en,
  output logic o_lvm_stop_en,
  output logic o_lvm_range_5v,
  output logic o_stop_enter,
  output logic o_illegal_stop,
  output logic o_stop_ready,
  output logic o_rst_pin_o,
  output logic o_rst_pin_oe,
  output logic o_wdog_cause
);
  import olw_pkg::*;

  olw_opt1_type opt1_q;
  olw_opt1_type opt1_v;
  olw_opt2_type opt2_q;
  logic opt1_done_q;
  logic opt2_done_q;
  logic range_q;
  logic range_done_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic test_hold;
  logic wd_active;
  logic [P_PRESC_W-1:0] presc_q;
  logic [WD_CNT_W-1:0] wd_cnt_q;
  logic wd_tick;
  logic wd_ovf;
  logic svc_wr;
  logic stop_ok;
  logic por_clr;
  logic [12:0] por_cnt_q;
  logic por_wait_q;
  logic [5:0] rst_cnt_q;
  logic cause_q;
  logic [12:0] rec_cnt_q;
  logic [1:0] cko_sel;
  logic [1:0] cko_lim;
  logic [1:0] cko_cnt_q;
  logic cko_src_tick;
  logic stop_enter_q;
  logic illegal_q;
  logic rec_done_q;
  logic clkout_q;

  // Address decode of a write strobe
  function automatic logic wr_hit(input logic [15:0] a);
    wr_hit = i_wr && (i_addr == a);
  endfunction : wr_hit

  // Option register two, one write per reset
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opt2_q <= olw_opt2_type'(OPT_RST);
      opt2_done_q <= 1'b0;
    end else if (wr_hit(ADDR_OPT2) && !opt2_done_q) begin
      opt2_q <= olw_opt2_type'(i_wdata & OPT2_WMASK);
      opt2_done_q <= 1'b1; // Later writes ignored
    end
  end

  // Option register one, one write per reset
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      opt1_q <= olw_opt1_type'(OPT_RST); // Rate bit cleared
      opt1_done_q <= 1'b0;
    end else if (wr_hit(ADDR_OPT1) && !opt1_done_q) begin
      opt1_q <= olw_opt1_type'(i_wdata);
      opt1_done_q <= 1'b1; // Later writes ignored
    end
  end

  // Range bit lives in the power-on domain
  always_ff @(posedge i_core_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      range_q <= 1'b0;
      range_done_q <= 1'b0;
    end else if (wr_hit(ADDR_OPT1) && !range_done_q) begin
      range_q <= i_wdata[3];
      range_done_q <= 1'b1;
    end
  end

  // Readback view of register one
  always_comb begin
    opt1_v = opt1_q;
    opt1_v.voltage_monitor_range_sel = range_q;
  end

  // Read data one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= RD_NONE;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_OPT2: o_rdata <= opt2_q;
        ADDR_OPT1: o_rdata <= opt1_v;
        ADDR_WDOG: o_rdata <= i_reset_vec_lo;
        default: o_rdata <= RD_NONE;
      endcase
    end else begin
      o_rdata <= RD_NONE;
    end
  end

  // Option outputs to the surrounding modules
  assign o_tb_div128_en = opt2_q.timebase_prescale_sel;
  assign o_osc_run_in_stop = opt2_q.osc_run_in_stop;
  assign o_serial_baud_bus = opt2_q.serial_baud_source;
  assign o_lvm_power_en = !opt1_q.voltage_monitor_power_disable;
  assign o_lvm_reset_en = !opt1_q.voltage_monitor_reset_disable;
  assign o_lvm_stop_en = opt1_q.voltage_monitor_in_stop &&
                         !opt1_q.voltage_monitor_power_disable;
  assign o_lvm_range_5v = range_q;

  // Clock-out divider limits
  assign cko_sel = {opt2_q.clock_output_div_hi, opt2_q.clock_output_div_lo};
  always_comb begin
    unique case (cko_sel)
      CKO_OFF: cko_lim = 2'h0;
      CKO_DIV1: cko_lim = 2'h0;
      CKO_DIV2: cko_lim = 2'h1;
      CKO_DIV4: cko_lim = 2'h3;
    endcase
  end
  assign cko_src_tick = opt2_q.clock_output_source_sel ? 1'b1 :
                        i_bus_tick;

  // Clock-out toggle counter
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cko_cnt_q <= 2'h0;
      clkout_q <= 1'b0;
    end else if (cko_sel == CKO_OFF) begin
      cko_cnt_q <= 2'h0;
      clkout_q <= 1'b0;
    end else if (cko_src_tick) begin
      if (cko_cnt_q >= cko_lim) begin
        cko_cnt_q <= 2'h0;
        clkout_q <= !clkout_q;
      end else begin
        cko_cnt_q <= cko_cnt_q + 2'h1;
      end
    end
  end

  // Clock-out pin routing
  assign o_clkout = clkout_q;
  assign o_clkout_pin_sel = (cko_sel != CKO_OFF);
  assign o_clkout_pin_oe = o_clkout_pin_sel && i_port_dir;

  // Two-flop synchronisers for mode and test-voltage pins
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_monitor_mode, i_break_state, i_rst_vtst, i_irq_vtst};
      sync2_q <= sync1_q;
    end
  end

  // Watchdog hold-off and enable
  assign test_hold = (sync2_q[3] && (sync2_q[1] || sync2_q[0])) ||
                     (sync2_q[2] && sync2_q[1]);
  assign wd_active = !opt1_q.watchdog_disable && !test_hold;

  // Service write and legal stop decode
  assign svc_wr = wr_hit(ADDR_WDOG);
  assign stop_ok = i_stop_exec && opt1_q.stop_enable;

  // Power-on prescaler clear after the settle count
  always_ff @(posedge i_core_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      por_cnt_q <= 13'h0000;
      por_wait_q <= 1'b1;
    end else if (por_wait_q) begin
      por_cnt_q <= por_cnt_q + 13'h0001;
      por_wait_q <= (por_cnt_q != POR_CLR_CYC - 13'h0001);
    end
  end
  assign por_clr = por_wait_q && (por_cnt_q == POR_CLR_CYC - 13'h0001);

  // System prescaler, free running
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc_q <= '0;
    end else if (stop_ok || por_clr) begin
      presc_q <= '0;
    end else if (svc_wr) begin
      presc_q <= presc_q & P_PRESC_W'((1 << PRESC_KEEP) - 1);
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // Overflow decode of the watchdog counter
  assign wd_tick = &presc_q;
  assign wd_ovf = wd_active && wd_tick &&
                  (opt1_q.watchdog_rate_sel ? wd_cnt_q[0] :
                   &wd_cnt_q);

  // Watchdog counter
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wd_cnt_q <= '0;
    end else if (!wd_active || svc_wr || wd_ovf) begin
      wd_cnt_q <= '0;
    end else if (wd_tick) begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // Reset pin pulse survives the internal reset it causes
  always_ff @(posedge i_core_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      rst_cnt_q <= 6'h00;
    end else if (wd_ovf) begin
      rst_cnt_q <= RST_PULSE_CYC;
    end else if (rst_cnt_q != 6'h00) begin
      rst_cnt_q <= rst_cnt_q - 6'h01;
    end
  end
  assign o_rst_pin_o = 1'b0;
  assign o_rst_pin_oe = (rst_cnt_q != 6'h00);

  // Watchdog cause flag, set wins over clear
  always_ff @(posedge i_core_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      cause_q <= 1'b0;
    end else if (wd_ovf) begin
      cause_q <= 1'b1;
    end else if (i_cause_clr) begin
      cause_q <= 1'b0;
    end
  end
  assign o_wdog_cause = cause_q;

  // Stop recovery delay counter
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rec_cnt_q <= 13'h0000;
      rec_done_q <= 1'b0;
    end else begin
      rec_done_q <= (rec_cnt_q == 13'h0001);
      if (i_stop_exit) begin
        rec_cnt_q <= (i_exit_by_reset || !opt1_q.short_stop_recovery) ?
                     REC_LONG : REC_SHORT;
      end else if (rec_cnt_q != 13'h0000) begin
        rec_cnt_q <= rec_cnt_q - 13'h0001;
      end
    end
  end
  assign o_stop_ready = rec_done_q;

  // Stop instruction outcome pulses
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stop_enter_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      stop_enter_q <= stop_ok;
      illegal_q <= i_stop_exec && !opt1_q.stop_enable;
    end
  end
  assign o_stop_enter = stop_enter_q;
  assign o_illegal_stop = illegal_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence seq_svc;
    svc_wr && !stop_ok && !por_clr;
  endsequence
  sequence seq_cleared;
    (wd_cnt_q == '0) && ((presc_q >> PRESC_KEEP) == '0);
  endsequence

  chk_opt_once: assert property (
    opt1_done_q |=> $stable(opt1_q))
    else $error("option register one changed after its write");
  chk_range_por: assert property (
    range_done_q |=> $stable(range_q))
    else $error("range bit changed after its write");
  chk_clkout_off: assert property (
    (cko_sel == CKO_OFF) |=> !o_clkout)
    else $error("clock-out active while off");
  chk_pin_gate: assert property (
    !i_port_dir |-> !o_clkout_pin_oe)
    else $error("clock-out driven with direction clear");
  chk_wd_off: assert property (
    opt1_q.watchdog_disable |-> !wd_ovf ##1 (wd_cnt_q == '0))
    else $error("disabled watchdog counted");
  chk_svc_clear: assert property (
    seq_svc |=> seq_cleared)
    else $error("service write did not clear watchdog");
  chk_pulse_len: assert property (
    $fell(o_rst_pin_oe) |-> $past(wd_ovf, 33))
    else $error("reset pin pulse not 32 cycles");
  chk_cause_set: assert property (
    wd_ovf |=> o_wdog_cause && o_rst_pin_oe)
    else $error("overflow did not set cause and pin");
  chk_stop_illegal: assert property (
    (i_stop_exec && !opt1_q.stop_enable) |=> o_illegal_stop && !o_stop_enter)
    else $error("disabled stop not flagged illegal");
  chk_rec_long: assert property (
    (i_stop_exit && i_exit_by_reset) |=> (rec_cnt_q == REC_LONG))
    else $error("reset exit did not take long recovery");
  chk_stop_clear: assert property (
    stop_ok |=> (presc_q == '0))
    else $error("stop did not clear the prescaler");
endmodule : olw_top

// ---- verification/test_olw_top.sv ----
// Self-checking bench for the option latches and watchdog
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %0h want %0h", $time, g, e); end end

module test_olw_top;
  import olw_pkg::*;
  localparam logic [1:0] CODE [5] = '{CKO_OFF, CKO_DIV1, CKO_DIV2,
    CKO_DIV4, CKO_DIV1};
  localparam logic SRC [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam int TOG [5] = '{0, 24, 12, 6, 12};
  localparam logic [3:0] HOLD [3] = '{4'h0, 4'h9, 4'h6};
  logic i_core_clk, i_arst_n, i_por_n, i_wr, i_rd, i_bus_tick;
  logic i_port_dir, i_stop_exec, i_stop_exit, i_exit_by_reset;
  logic i_monitor_mode, i_break_state, i_rst_vtst, i_irq_vtst;
  logic i_cause_clr, o_clkout, o_clkout_pin_sel, o_clkout_pin_oe;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, i_reset_vec_lo, o_rdata, rexp, v1, v2;
  logic o_tb_div128_en, o_osc_run_in_stop, o_serial_baud_bus;
  logic o_lvm_power_en, o_lvm_reset_en, o_lvm_stop_en, o_lvm_range_5v;
  logic o_stop_enter, o_illegal_stop, o_stop_ready, o_rst_pin_o;
  logic o_rst_pin_oe, o_wdog_cause, prev;
  logic take_rd = 1'b0;
  logic [7:0] exp_q [$];
  olw_opt1_type o1;
  olw_opt2_type o2;
  int fails = 0;
  int check_count = 0;
  int oe_cycles = 0;
  int n;
  logic [31:0] r;

  olw_top #(.P_PRESC_W(5)) dut (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_por_n(i_por_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_reset_vec_lo(i_reset_vec_lo), .i_bus_tick(i_bus_tick),
    .i_port_dir(i_port_dir), .i_stop_exec(i_stop_exec),
    .i_stop_exit(i_stop_exit), .i_exit_by_reset(i_exit_by_reset),
    .i_monitor_mode(i_monitor_mode), .i_break_state(i_break_state),
    .i_rst_vtst(i_rst_vtst), .i_irq_vtst(i_irq_vtst),
    .i_cause_clr(i_cause_clr), .o_rdata(o_rdata), .o_clkout(o_clkout),
    .o_clkout_pin_sel(o_clkout_pin_sel),
    .o_clkout_pin_oe(o_clkout_pin_oe), .o_tb_div128_en(o_tb_div128_en),
    .o_osc_run_in_stop(o_osc_run_in_stop),
    .o_serial_baud_bus(o_serial_baud_bus),
    .o_lvm_power_en(o_lvm_power_en), .o_lvm_reset_en(o_lvm_reset_en),
    .o_lvm_stop_en(o_lvm_stop_en), .o_lvm_range_5v(o_lvm_range_5v),
    .o_stop_enter(o_stop_enter), .o_illegal_stop(o_illegal_stop),
    .o_stop_ready(o_stop_ready), .o_rst_pin_o(o_rst_pin_o),
    .o_rst_pin_oe(o_rst_pin_oe), .o_wdog_cause(o_wdog_cause));

  // Clock and a bus tick every second cycle
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) i_bus_tick <= ~i_bus_tick;

  // Read data compared the cycle after the strobe; reset pulse length
  always @(posedge i_core_clk) take_rd <= i_rd;
  always @(negedge i_core_clk) begin
    if (take_rd) begin
      rexp = exp_q.pop_front();
      `CHK(o_rdata, rexp)
    end
    if (o_rst_pin_oe === 1'b1) oe_cycles++;
  end

  task automatic conclude;
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask : rd

  task automatic restart;
    @(posedge i_core_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
  endtask : restart

  // Stop instruction outcome, legal or illegal
  task automatic stp(input logic en);
    @(posedge i_core_clk);
    i_stop_exec <= 1'b1;
    @(posedge i_core_clk);
    i_stop_exec <= 1'b0;
    @(negedge i_core_clk);
    `CHK(o_stop_enter, en)
    `CHK(o_illegal_stop, ~en)
  endtask : stp

  // Cycles from stop exit strobe to recovery done
  task automatic rec(input logic by_rst, input int e);
    int k;
    @(posedge i_core_clk);
    i_stop_exit <= 1'b1;
    i_exit_by_reset <= by_rst;
    @(posedge i_core_clk);
    i_stop_exit <= 1'b0;
    k = 1;
    @(negedge i_core_clk);
    while (o_stop_ready !== 1'b1 && k < 5000) begin
      k++;
      @(negedge i_core_clk);
    end
    if (k == 5000) begin fails++; conclude(); end
    `CHK(k, e)
  endtask : rec

  // Timeout window, then pulse length and cause flag
  task automatic wait_oe(input int lo, input int hi);
    int k;
    k = 0;
    oe_cycles = 0;
    while (o_rst_pin_oe !== 1'b1 && k < hi) begin
      @(negedge i_core_clk);
      k++;
    end
    if (k == hi) begin fails++; conclude(); end
    `CHK(k >= lo, 1'b1)
    repeat (40) @(posedge i_core_clk);
    `CHK(oe_cycles, 32)
    `CHK(o_wdog_cause, 1'b1)
    `CHK(o_rst_pin_o, 1'b0)
  endtask : wait_oe

  // Main sequence
  initial begin
    {i_core_clk, i_arst_n, i_por_n, i_wr, i_rd, i_bus_tick} = '0;
    {i_port_dir, i_stop_exec, i_stop_exit, i_exit_by_reset} = '0;
    {i_monitor_mode, i_break_state, i_rst_vtst, i_irq_vtst} = '0;
    {i_cause_clr, i_addr, i_wdata} = '0;
    void'($urandom(76));
    i_reset_vec_lo = 8'($urandom);
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    i_por_n <= 1'b1;
    @(negedge i_core_clk);
    `CHK({o_lvm_power_en, o_lvm_reset_en, o_wdog_cause}, 3'h6)
    rd(ADDR_OPT2, OPT_RST);
    rd(ADDR_OPT1, OPT_RST);
    rd(ADDR_WDOG, i_reset_vec_lo);
    rd(16'h0020, RD_NONE);
    wr(ADDR_OPT1, 8'h09);
    @(negedge i_core_clk);
    `CHK(o_lvm_range_5v, 1'b1)
    // Option latching, write-once, clock-out modes
    for (int i = 0; i < 5; i++) begin
      r = $urandom;
      v2 = {SRC[i], CODE[i], r[4:0]};
      v1 = {1'b0, r[10:8], 1'b0, r[12] & r[1], r[11], 1'b1};
      i_port_dir <= r[13];
      restart();
      wr(ADDR_OPT2, v2);
      wr(ADDR_OPT1, v1);
      wr(ADDR_OPT2, ~v2);
      wr(ADDR_OPT1, ~v1);
      rd(ADDR_OPT2, v2 & OPT2_WMASK);
      rd(ADDR_OPT1, v1 | 8'h08);
      o1 = olw_opt1_type'(v1);
      o2 = olw_opt2_type'(v2);
      repeat (4) @(negedge i_core_clk);
      `CHK(o_clkout_pin_sel, CODE[i] != CKO_OFF)
      `CHK(o_clkout_pin_oe, (CODE[i] != CKO_OFF) & r[13])
      `CHK(o_tb_div128_en, o2.timebase_prescale_sel)
      `CHK(o_osc_run_in_stop, o2.osc_run_in_stop)
      `CHK(o_serial_baud_bus, o2.serial_baud_source)
      `CHK(o_lvm_power_en, ~o1.voltage_monitor_power_disable)
      `CHK(o_lvm_reset_en, ~o1.voltage_monitor_reset_disable)
      if (!o1.voltage_monitor_power_disable)
        `CHK(o_lvm_stop_en, o1.voltage_monitor_in_stop)
      else
        `CHK(o_lvm_stop_en, 1'b0)
      `CHK(o_lvm_range_5v, 1'b1)
      n = 0;
      prev = o_clkout;
      repeat (24) begin
        @(negedge i_core_clk);
        if (o_clkout !== prev) n++;
        prev = o_clkout;
      end
      `CHK(n, TOG[i])
    end
    // Stop instruction and recovery delays
    restart();
    wr(ADDR_OPT2, 8'h02); // Oscillator kept running
    wr(ADDR_OPT1, 8'h07);
    stp(1'b1);
    rec(1'b0, int'(REC_SHORT) + 1);
    rec(1'b1, int'(REC_LONG) + 1);
    restart();
    wr(ADDR_OPT1, 8'h01);
    stp(1'b0);
    rec(1'b0, int'(REC_LONG) + 1);
    // Watchdog servicing, short and long timeouts
    restart();
    wr(ADDR_OPT1, 8'h80);
    oe_cycles = 0;
    repeat (10) begin
      wr(ADDR_WDOG, 8'($urandom));
      repeat (30) @(posedge i_core_clk);
    end
    `CHK(oe_cycles, 0)
    wr(ADDR_WDOG, 8'($urandom));
    wait_oe(44, 72);
    i_cause_clr <= 1'b1;
    @(posedge i_core_clk);
    i_cause_clr <= 1'b0;
    @(negedge i_core_clk);
    `CHK(o_wdog_cause, 1'b0)
    restart();
    wr(ADDR_OPT1, 8'h00);
    wr(ADDR_WDOG, 8'($urandom));
    wait_oe(2020, 2070);
    // Disable bit and test-voltage holds
    for (int i = 0; i < 3; i++) begin
      {i_monitor_mode, i_break_state, i_rst_vtst, i_irq_vtst} <= HOLD[i];
      restart();
      wr(ADDR_OPT1, (i == 0) ? 8'h81 : 8'h80);
      oe_cycles = 0;
      repeat (150) @(posedge i_core_clk);
      `CHK(oe_cycles, 0)
    end
    {i_monitor_mode, i_break_state, i_rst_vtst, i_irq_vtst} <= 4'h0;
    `CHK(o_wdog_cause, 1'b1)
    // Power-on reset clears range bit and cause flag
    i_por_n <= 1'b0;
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_por_n <= 1'b1;
    i_arst_n <= 1'b1;
    @(negedge i_core_clk);
    `CHK({o_lvm_range_5v, o_wdog_cause}, 2'h0)
    rd(ADDR_OPT1, OPT_RST);
    repeat (2) @(posedge i_core_clk);
    conclude();
  end
endmodule : test_olw_top
